// ==== verilog/tps_regs.svh ====
// tps_regs.svh: constants of the timer read-back synchroniser
// assumes: included by the package and by the design modules
`ifndef TPS_REGS_SVH
`define TPS_REGS_SVH

// ----------------------------------------------------------------
// read selectors
// ----------------------------------------------------------------
`define TPS_SEL_GPCNT 3'h0
`define TPS_SEL_CAP1 3'h1
`define TPS_SEL_CAP2 3'h2
`define TPS_SEL_WDT 3'h3
`define TPS_SEL_SYNC 3'h4
`define TPS_SEL_REV 3'h5
`define TPS_SEL_LAST 3'h5

// ----------------------------------------------------------------
// values and timing
// ----------------------------------------------------------------
`define TPS_WIDTH 32
`define TPS_ZERO 32'h0000_0000
`define TPS_ONE 32'h0000_0001
`define TPS_WDT_LOAD 32'hFFFF_FFFF
// arbitrary revision value, names no product
`define TPS_REV_VALUE 32'h0000_0A5A
// interface clock cycles that must pass after wake
`define TPS_IF_WAIT 2'h2
`define TPS_IF_ZERO 2'h0
`define TPS_IF_STEP 2'h1

`endif

// ==== verilog/tps_pkg.sv ====
// tps_pkg.sv: types of the timer read-back synchroniser
// assumes: tps_regs.svh is on the include path
`include "tps_regs.svh"

package tps_pkg;

  // wake guard, gray coded along sleep -> if wait -> fn wait -> ready
  typedef enum logic [1:0] {
    TPS_SLEEP = 2'b00,
    TPS_WAKE_IF = 2'b01,
    TPS_WAKE_FN = 2'b11,
    TPS_READY = 2'b10
  } tps_guard_t;

  // which value a read returns
  typedef enum logic [2:0] {
    TPS_RD_GPCNT = `TPS_SEL_GPCNT,
    TPS_RD_CAP1 = `TPS_SEL_CAP1,
    TPS_RD_CAP2 = `TPS_SEL_CAP2,
    TPS_RD_WDT = `TPS_SEL_WDT,
    TPS_RD_SYNC = `TPS_SEL_SYNC,
    TPS_RD_REV = `TPS_SEL_REV
  } tps_sel_t;

endpackage : tps_pkg

// ==== verilog/tps_shadow.sv ====
// tps_shadow.sv: one posted shadow word of the interface side
// assumes: single clock core_clk, async active-low reset
`timescale 1ns/1ps
`include "tps_regs.svh"

module tps_shadow (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic loadEn,
  input wire logic [`TPS_WIDTH-1:0] liveVal,
  output logic [`TPS_WIDTH-1:0] heldVal
);
  import tps_pkg::*;

  logic [`TPS_WIDTH-1:0] held_reg;
  logic [`TPS_WIDTH-1:0] held_next;

  // follows the live word only while the interface clock runs
  always_comb begin
    held_next = loadEn ? liveVal : held_reg;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      held_reg <= `TPS_ZERO;
    end else begin
      held_reg <= held_next;
    end
  end

  assign heldVal = held_reg;

endmodule : tps_shadow

// ==== verilog/tps_readback_sync.sv ====
// tps_readback_sync.sv: counters, captures and posted read-back with wake guard
// assumes: ifClkRun and funcClkTick are pins from other domains,
// everything else comes from logic on core_clk
`timescale 1ns/1ps
`include "tps_regs.svh"

// Notes on behaviour
// - posted general counter reads right after interface wake may be stale.
// - non-posted general counter reads are correct immediately after wake.
// - watchdog counter reads share the stale hazard after wake.
// - watchdog is always posted; no setting selects non-posted.
// - sync counter and revision are always posted, so stale after wake.
module tps_readback_sync (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ifClkRun,
  input wire logic funcClkTick,
  input wire logic postedMode,
  input wire logic captureOne,
  input wire logic captureTwo,
  input wire logic readReq,
  input wire tps_pkg::tps_sel_t readSel,
  output logic [`TPS_WIDTH-1:0] readData,
  output logic readAck,
  output logic readFresh,
  output logic syncReady
);
  import tps_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] runSync_reg, runSync_next;
  logic [2:0] tickSync_reg, tickSync_next;
  logic ifActive_reg, ifActive_next;
  logic tickLvl_reg, tickLvl_next;
  logic tickDly_reg, tickDly_next;
  logic tickPast_reg, tickPast_next;
  logic tickPulse;

  // level changes once stages two and three agree
  always_comb begin
    runSync_next = {runSync_reg[1:0], ifClkRun};
    tickSync_next = {tickSync_reg[1:0], funcClkTick};
    ifActive_next = (runSync_reg[1] == runSync_reg[2]) ? runSync_reg[2] : ifActive_reg;
    tickLvl_next = (tickSync_reg[1] == tickSync_reg[2]) ? tickSync_reg[2] : tickLvl_reg;
    tickDly_next = tickLvl_reg;
    tickPast_next = tickPulse;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      runSync_reg <= 3'h0;
      tickSync_reg <= 3'h0;
      ifActive_reg <= 1'b0;
      tickLvl_reg <= 1'b0;
      tickDly_reg <= 1'b0;
      tickPast_reg <= 1'b0;
    end else begin
      runSync_reg <= runSync_next;
      tickSync_reg <= tickSync_next;
      ifActive_reg <= ifActive_next;
      tickLvl_reg <= tickLvl_next;
      tickDly_reg <= tickDly_next;
      tickPast_reg <= tickPast_next;
    end
  end

  // one functional tick per rising edge of the filtered level
  assign tickPulse = tickLvl_reg & ~tickDly_reg;

  // ----------------------------------------------------------------
  // functional-domain counters
  // ----------------------------------------------------------------
  logic [`TPS_WIDTH-1:0] gpCnt_reg, gpCnt_next;
  logic [`TPS_WIDTH-1:0] cap1_reg, cap1_next;
  logic [`TPS_WIDTH-1:0] cap2_reg, cap2_next;
  logic [`TPS_WIDTH-1:0] wdtCnt_reg, wdtCnt_next;
  logic [`TPS_WIDTH-1:0] syncCnt_reg, syncCnt_next;

  // all counting happens on the functional tick only
  always_comb begin
    gpCnt_next = tickPulse ? gpCnt_reg + `TPS_ONE : gpCnt_reg;
    cap1_next = captureOne ? gpCnt_reg : cap1_reg;
    cap2_next = captureTwo ? gpCnt_reg : cap2_reg;
    wdtCnt_next = wdtCnt_reg;
    if (tickPulse) begin
      wdtCnt_next = (wdtCnt_reg == `TPS_ZERO) ? `TPS_WDT_LOAD : wdtCnt_reg - `TPS_ONE;
    end
    syncCnt_next = tickPulse ? syncCnt_reg + `TPS_ONE : syncCnt_reg;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      gpCnt_reg <= `TPS_ZERO;
      cap1_reg <= `TPS_ZERO;
      cap2_reg <= `TPS_ZERO;
      wdtCnt_reg <= `TPS_WDT_LOAD;
      syncCnt_reg <= `TPS_ZERO;
    end else begin
      gpCnt_reg <= gpCnt_next;
      cap1_reg <= cap1_next;
      cap2_reg <= cap2_next;
      wdtCnt_reg <= wdtCnt_next;
      syncCnt_reg <= syncCnt_next;
    end
  end

  // ----------------------------------------------------------------
  // posted shadows, frozen while the interface clock is stopped
  // ----------------------------------------------------------------
  logic [`TPS_WIDTH-1:0] liveArr [0:`TPS_SEL_LAST];
  logic [`TPS_WIDTH-1:0] heldArr [0:`TPS_SEL_LAST];

  assign liveArr[`TPS_SEL_GPCNT] = gpCnt_reg;
  assign liveArr[`TPS_SEL_CAP1] = cap1_reg;
  assign liveArr[`TPS_SEL_CAP2] = cap2_reg;
  assign liveArr[`TPS_SEL_WDT] = wdtCnt_reg;
  assign liveArr[`TPS_SEL_SYNC] = syncCnt_reg;
  assign liveArr[`TPS_SEL_REV] = `TPS_REV_VALUE;

  // the stale window is exactly the frozen content of these shadows
  generate
    for (genvar i = 0; i <= `TPS_SEL_LAST; i++) begin : gShadow
      tps_shadow uShadow (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .loadEn(ifActive_reg),
        .liveVal(liveArr[i]),
        .heldVal(heldArr[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // wake guard
  // ----------------------------------------------------------------
  tps_guard_t guard_reg, guard_next;
  logic [1:0] ifCnt_reg, ifCnt_next;

  // two interface cycles, then one tick that the shadows have absorbed
  always_comb begin
    guard_next = guard_reg;
    ifCnt_next = ifCnt_reg;
    case (guard_reg)
      TPS_SLEEP: begin
        ifCnt_next = `TPS_IF_ZERO;
        if (ifActive_reg) begin
          guard_next = TPS_WAKE_IF;
        end
      end
      TPS_WAKE_IF: begin
        if (ifCnt_reg == `TPS_IF_WAIT - `TPS_IF_STEP) begin
          guard_next = TPS_WAKE_FN;
        end else begin
          ifCnt_next = ifCnt_reg + `TPS_IF_STEP;
        end
      end
      TPS_WAKE_FN: begin
        // waits for the tick one cycle back so the shadow already holds it
        if (tickPast_reg) begin
          guard_next = TPS_READY;
        end
      end
      TPS_READY: begin
        guard_next = TPS_READY;
      end
      default: begin
        guard_next = TPS_SLEEP;
      end
    endcase
    if (!ifActive_reg) begin
      guard_next = TPS_SLEEP;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      guard_reg <= TPS_SLEEP;
      ifCnt_reg <= `TPS_IF_ZERO;
    end else begin
      guard_reg <= guard_next;
      ifCnt_reg <= ifCnt_next;
    end
  end

  assign syncReady = (guard_reg == TPS_READY);

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  logic [`TPS_WIDTH-1:0] rdData_reg, rdData_next;
  logic rdAck_reg, rdAck_next;
  logic rdFresh_reg, rdFresh_next;
  logic selPosted;
  logic selValid;
  logic [2:0] rdIdx;

  // watchdog, sync counter and revision ignore postedMode
  always_comb begin
    rdIdx = readSel;
    selValid = (rdIdx <= `TPS_SEL_LAST);
    selPosted = postedMode || (rdIdx >= `TPS_SEL_WDT);
    rdAck_next = readReq;
    rdData_next = rdData_reg;
    rdFresh_next = rdFresh_reg;
    if (readReq) begin
      if (!selValid) begin
        rdData_next = `TPS_ZERO;
        rdFresh_next = 1'b1;
      end else if (selPosted) begin
        rdData_next = heldArr[rdIdx];
        rdFresh_next = syncReady;
      end else begin
        rdData_next = liveArr[rdIdx];
        rdFresh_next = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdData_reg <= `TPS_ZERO;
      rdAck_reg <= 1'b0;
      rdFresh_reg <= 1'b0;
    end else begin
      rdData_reg <= rdData_next;
      rdAck_reg <= rdAck_next;
      rdFresh_reg <= rdFresh_next;
    end
  end

  assign readData = rdData_reg;
  assign readAck = rdAck_reg;
  assign readFresh = rdFresh_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_guard_sleeps: assert property (@(posedge core_clk) disable iff (!rst_b)
    !ifActive_reg |=> guard_reg == TPS_SLEEP)
    else $error("guard not asleep after interface stop");

  a_if_wait_two: assert property (@(posedge core_clk) disable iff (!rst_b)
    (guard_reg == TPS_SLEEP && ifActive_reg) ##1 ifActive_reg |=> guard_reg == TPS_WAKE_IF)
    else $error("interface wait shorter than two cycles");

  a_ready_after_tick: assert property (@(posedge core_clk) disable iff (!rst_b)
    (guard_reg == TPS_WAKE_FN) ##1 (guard_reg == TPS_READY) |-> $past(tickPast_reg))
    else $error("ready without a functional tick");

  a_nonposted_direct: assert property (@(posedge core_clk) disable iff (!rst_b)
    readReq && !postedMode && rdIdx <= `TPS_SEL_CAP2 |=> readFresh && readData == $past(liveArr[rdIdx]))
    else $error("non-posted read not current");

  a_posted_stale: assert property (@(posedge core_clk) disable iff (!rst_b)
    readReq && postedMode && rdIdx <= `TPS_SEL_CAP2 && !syncReady |=> readAck && !readFresh)
    else $error("posted read trusted before wake wait");

  a_wdt_posted: assert property (@(posedge core_clk) disable iff (!rst_b)
    readReq && rdIdx == `TPS_SEL_WDT && !syncReady |=> !readFresh && readData == $past(heldArr[`TPS_SEL_WDT]))
    else $error("watchdog read not posted");

  a_sync_posted: assert property (@(posedge core_clk) disable iff (!rst_b)
    readReq && (rdIdx == `TPS_SEL_SYNC || rdIdx == `TPS_SEL_REV) && !syncReady |=> !readFresh)
    else $error("sync timer read trusted too early");

  a_ready_current: assert property (@(posedge core_clk) disable iff (!rst_b)
    readReq && syncReady && selValid && !$past(tickPulse) && !$past(captureOne) && !$past(captureTwo)
      |=> readFresh && readData == $past(liveArr[rdIdx]))
    else $error("read after wake wait not current");

endmodule : tps_readback_sync

// ==== tb/tps_sw_model.sv ====
// tps_sw_model.sv: software reader on the far side of the read port
// assumes: core_clk domain, bench asks for one read at a time via go
`timescale 1ns/1ps

module tps_sw_model (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic go,
  input wire tps_pkg::tps_sel_t goSel,
  input wire logic honorWait,
  input wire logic syncReady,
  output logic readReq,
  output tps_pkg::tps_sel_t readSel
);
  import tps_pkg::*;
  logic pend_reg;
  logic wait_reg;
  // ----------------------------------------------------------------
  // request issue
  // ----------------------------------------------------------------
  // a polite reader holds its read back until the wake wait is over
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
      wait_reg <= 1'b0;
      readReq <= 1'b0;
      readSel <= TPS_RD_GPCNT;
    end else begin
      readReq <= 1'b0;
      if (go) begin
        pend_reg <= 1'b1;
        wait_reg <= honorWait;
        readSel <= goSel;
      end else if (pend_reg && (!wait_reg || syncReady)) begin
        readReq <= 1'b1;
        pend_reg <= 1'b0;
      end
    end
  end
endmodule : tps_sw_model

// ==== tb/timer_posted_readback_sync_bench.sv ====
// timer_posted_readback_sync_bench.sv: self-checking bench of the read-back block
// assumes: tps_pkg compiled first, tps_regs.svh on the include path
`timescale 1ns/1ps
`include "tps_regs.svh"

module timer_posted_readback_sync_bench;
  import tps_pkg::*;
  logic core_clk, rst_b, ifClkRun, funcClkTick, postedMode, captureOne, captureTwo;
  logic go, honorWait, readReq, readAck, readFresh, syncReady;
  tps_sel_t goSel, readSel;
  logic [31:0] readData;
  int failCount = 0;
  int checked = 0;
  int cycles = 0;

  tps_sw_model sw_u (.core_clk(core_clk), .rst_b(rst_b), .go(go), .goSel(goSel),
    .honorWait(honorWait), .syncReady(syncReady), .readReq(readReq), .readSel(readSel));
  tps_readback_sync dut_u (.core_clk(core_clk), .rst_b(rst_b), .ifClkRun(ifClkRun),
    .funcClkTick(funcClkTick), .postedMode(postedMode), .captureOne(captureOne),
    .captureTwo(captureTwo), .readReq(readReq), .readSel(readSel), .readData(readData),
    .readAck(readAck), .readFresh(readFresh), .syncReady(syncReady));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failCount++;
      finishTest();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic finishTest();
    if (failCount == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finishTest

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wait_cyc

  // slow functional edge, long enough to pass the 3-stage filter
  task automatic tick();
    @(posedge core_clk) funcClkTick <= 1'b1;
    wait_cyc(6);
    funcClkTick <= 1'b0;
    wait_cyc(8);
  endtask : tick

  // one read through the software model, judged on the ack cycle
  task automatic rd(input tps_sel_t s, input logic hw, input logic chkData, input logic [31:0] expData,
                    input logic expFresh);
    int n;
    @(posedge core_clk);
    go <= 1'b1;
    goSel <= s;
    honorWait <= hw;
    @(posedge core_clk) go <= 1'b0;
    for (n = 0; n < 200; n++) begin
      @(posedge core_clk);
      #1;
      if (readAck === 1'b1) break;
    end
    check("readAck", 1'b1, readAck);
    if (chkData) check("readData", expData, readData);
    check("readFresh", expFresh, readFresh);
    @(posedge core_clk);
    #1;
    check("readAck width", 1'b0, readAck);
  endtask : rd

  task automatic pulse_cap(input logic two);
    @(posedge core_clk);
    if (two) captureTwo <= 1'b1;
    else captureOne <= 1'b1;
    @(posedge core_clk);
    captureOne <= 1'b0;
    captureTwo <= 1'b0;
  endtask : pulse_cap

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // first wake: ready only after interface cycles and one tick
  task automatic first_wake();
    @(posedge core_clk) ifClkRun <= 1'b1;
    wait_cyc(20);
    check("syncReady before tick", 1'b0, syncReady);
    tick();
    check("syncReady after tick", 1'b1, syncReady);
    rd(TPS_RD_GPCNT, 1'b0, 1'b1, 32'h0000_0001, 1'b1);
    @(posedge core_clk) postedMode <= 1'b1;
    rd(TPS_RD_GPCNT, 1'b1, 1'b1, 32'h0000_0001, 1'b1);
    rd(TPS_RD_REV, 1'b1, 1'b1, `TPS_REV_VALUE, 1'b1);
  endtask : first_wake

  // interface sleeps while counters run, reads taken right at wake
  task automatic stale_after_wake();
    @(posedge core_clk) ifClkRun <= 1'b0;
    wait_cyc(10);
    check("syncReady asleep", 1'b0, syncReady);
    tick();
    tick();
    @(posedge core_clk) ifClkRun <= 1'b1;
    rd(TPS_RD_GPCNT, 1'b0, 1'b1, 32'h0000_0001, 1'b0);
    @(posedge core_clk) postedMode <= 1'b0;
    rd(TPS_RD_WDT, 1'b0, 1'b0, 32'h0, 1'b0);
    rd(TPS_RD_SYNC, 1'b0, 1'b0, 32'h0, 1'b0);
    rd(TPS_RD_REV, 1'b0, 1'b0, 32'h0, 1'b0);
    rd(TPS_RD_GPCNT, 1'b0, 1'b1, 32'h0000_0003, 1'b1);
  endtask : stale_after_wake

  // after the wait every counter, capture and watchdog value matches the functional side
  task automatic fresh_after_wait();
    @(posedge core_clk) postedMode <= 1'b1;
    tick();
    rd(TPS_RD_GPCNT, 1'b1, 1'b1, 32'h0000_0004, 1'b1);
    pulse_cap(1'b0);
    tick();
    pulse_cap(1'b1);
    wait_cyc(3);
    rd(TPS_RD_CAP1, 1'b1, 1'b1, 32'h0000_0004, 1'b1);
    rd(TPS_RD_CAP2, 1'b1, 1'b1, 32'h0000_0005, 1'b1);
    rd(TPS_RD_WDT, 1'b1, 1'b1, 32'hFFFF_FFFA, 1'b1);
    rd(TPS_RD_SYNC, 1'b1, 1'b1, 32'h0000_0005, 1'b1);
    rd(TPS_RD_GPCNT, 1'b1, 1'b1, 32'h0000_0005, 1'b1);
    // unused selector codes read zero and are always trusted
    rd(tps_sel_t'(3'h6), 1'b0, 1'b1, `TPS_ZERO, 1'b1);
  endtask : fresh_after_wait

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    ifClkRun = 1'b0;
    funcClkTick = 1'b0;
    postedMode = 1'b0;
    captureOne = 1'b0;
    captureTwo = 1'b0;
    go = 1'b0;
    goSel = TPS_RD_GPCNT;
    honorWait = 1'b0;
    wait_cyc(16);
    check("syncReady in reset", 1'b0, syncReady);
    rst_b <= 1'b1;
    first_wake();
    stale_after_wake();
    fresh_after_wait();
    finishTest();
  end
endmodule : timer_posted_readback_sync_bench
